/* logic/gsp_consts.vh */
// Purpose: constants for the gesture sensor serial host controller
// Assumes: 10 MHz system clock
// Notes: timing counts are derived from times in ns
`ifndef GSP_CONSTS_VH
`define GSP_CONSTS_VH
`define GSP_CLK_NS 100
// two-wire bit quarter period (400 kHz bus -> 2500 ns bit, 625 ns quarter)
`define GSP_I2C_QTR_NS 625
`define GSP_I2C_QTR_CYC ((`GSP_I2C_QTR_NS + `GSP_CLK_NS - 1) / `GSP_CLK_NS)
// four-wire half period; miso crosses two sync flops, so each half must be
// three cycles long for a bit launched at the falling edge to arrive in time
`define GSP_SPI_HALF_NS 300
`define GSP_SPI_HALF_CYC ((`GSP_SPI_HALF_NS + `GSP_CLK_NS - 1) / `GSP_CLK_NS)
// target addresses (write form, read form adds one)
`define GSP_ADDR_BASE 8'h9E
`define GSP_ADDR_STRAP_ADD 8'h02
`define GSP_TOP_REG 8'hFF
`define GSP_RSV_LO 8'hB0
`define GSP_RSV_HI 8'hC0
`define GSP_CMD_READ 8'h80
`define GSP_CMD_WRITE 8'h00
`define GSP_SPI_BITS 24
`endif

/* logic/gsp_tick.v */
// Purpose: divider giving a one-cycle enable pulse every DIV cycles
// Assumes: DIV at least 1
// Notes: restarts when i_clr is high
`timescale 1ns/1ps
module gsp_tick #(
    parameter DIV = 1
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // control
    input wire i_clr,
    output reg o_tick
);
    reg [7:0] cnt_r;

    ////////////////////////////////////////////////////////////////////
    // count up, pulse on wrap
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= 8'h00;
            o_tick <= 1'b0;
        end else if (i_clr) begin
            cnt_r <= 8'h00;
            o_tick <= 1'b0;
        end else if (cnt_r == DIV[7:0] - 8'h01) begin
            cnt_r <= 8'h00;
            o_tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
            o_tick <= 1'b0;
        end
    end
endmodule // gsp_tick

/* logic/gsp_sync.v */
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: RST_VAL is the idle level of the pin
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module gsp_sync #(
    parameter RST_VAL = 1'b1
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // pin
    input wire i_d,
    output reg o_q
);
    reg meta_r;

    ////////////////////////////////////////////////////////////////////
    // two stages
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_r <= RST_VAL;
            o_q <= RST_VAL;
        end else begin
            meta_r <= i_d;
            o_q <= meta_r;
        end
    end
endmodule // gsp_sync

/* logic/gsp_host.v */
// Purpose: host controller for the gesture sensor serial register port
// Assumes: 10 MHz clock; i_mode_2w chooses the bus; one command at a time
// Notes: two-wire pointed reads issue start, address, pointer, repeated start,
//        read, one byte per i_len; four-wire transfers use 24-bit frames, and read bursts add 8 bits per i_len
// How it works
// - write frame: address with direction 0, then the pointer byte
// - write frame ends with a stop after the last data byte, or after the pointer when i_len is zero
// - pointed read: write address, pointer, repeated start, read address
// - reserved register range flagged to the user on two-wire read
// - ack every read byte but the last; last gets nack then stop
// - read data sampled on the rising serial clock edge
// - four-wire frame framed by select low, data for rising capture
// - serial clock idles low, mode zero only
// - frame is address byte, command byte, data byte, 24 bits
// - select raised between operations; clock held low while raised
`timescale 1ns/1ps
`include "gsp_consts.vh"
module gsp_host (
    // clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // user command
    input wire i_start,
    input wire i_mode_2w,
    input wire i_strap,
    input wire i_rd,
    input wire i_use_ptr,
    input wire [7:0] i_reg,
    input wire [7:0] i_len,
    input wire [7:0] i_wdata,
    output reg o_wreq,
    output reg [7:0] o_rdata,
    output reg o_rvalid,
    output reg o_rsv,
    output reg o_busy,
    output reg o_done,
    output reg o_nack,
    // two-wire pins
    input wire i_scl,
    output reg o_scl_oe,
    input wire i_sda,
    output reg o_sda_oe,
    // four-wire pins
    output reg o_cs_b,
    output reg o_sclk,
    output reg o_mosi,
    input wire i_miso
);
    localparam ST_IDLE = 4'd0;
    localparam ST_START = 4'd1;
    localparam ST_BIT = 4'd2;
    localparam ST_ACK = 4'd3;
    localparam ST_STOP = 4'd4;
    localparam ST_RSTART = 4'd5;
    localparam ST_SBIT = 4'd6;
    localparam ST_SEND = 4'd7;
    localparam ST_DONE = 4'd8;
    // byte roles on the two-wire bus
    localparam B_AW = 3'd0;
    localparam B_PTR = 3'd1;
    localparam B_WD = 3'd2;
    localparam B_AR = 3'd3;
    localparam B_RD = 3'd4;

    reg rst_m_r, rst_r;
    wire sda_s, scl_s, miso_s;
    wire tick2, tick4;
    reg [3:0] st_r;
    reg [2:0] role_r;
    reg [1:0] ph_r;
    reg [4:0] bit_r;
    reg [7:0] sh_r;
    reg [23:0] ssh_r;
    reg [7:0] left_r;
    reg [7:0] cur_r;
    reg rd_r, ptr_r;
    reg [7:0] reg_r;

    // address byte for the chosen strap, direction in bit 0
    function [7:0] taddr;
        input strap;
        input rd;
        begin
            taddr = `GSP_ADDR_BASE + (strap ? `GSP_ADDR_STRAP_ADD : 8'h00)
                + {7'h00, rd};
        end
    endfunction

    function rsv_reg;
        input [7:0] r;
        begin
            rsv_reg = (r >= `GSP_RSV_LO) && (r <= `GSP_RSV_HI);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_m_r <= 1'b0;
            rst_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_r <= rst_m_r;
        end
    end

    gsp_sync #(.RST_VAL(1'b1)) u_sda (
        .i_clk(i_clk), .i_rst_b(rst_r), .i_d(i_sda), .o_q(sda_s));
    gsp_sync #(.RST_VAL(1'b1)) u_scl (
        .i_clk(i_clk), .i_rst_b(rst_r), .i_d(i_scl), .o_q(scl_s));
    gsp_sync #(.RST_VAL(1'b0)) u_miso (
        .i_clk(i_clk), .i_rst_b(rst_r), .i_d(i_miso), .o_q(miso_s));

    // quarter-bit enable for two-wire, half-period enable for four-wire
    gsp_tick #(.DIV(`GSP_I2C_QTR_CYC)) u_t2 (
        .i_clk(i_clk), .i_rst_b(rst_r), .i_clr(st_r == ST_IDLE), .o_tick(tick2));
    gsp_tick #(.DIV(`GSP_SPI_HALF_CYC)) u_t4 (
        .i_clk(i_clk), .i_rst_b(rst_r), .i_clr(st_r == ST_IDLE), .o_tick(tick4));

    ////////////////////////////////////////////////////////////////////
    // main sequencer; scl stretching is honoured by waiting for scl high
    always @(posedge i_clk or negedge rst_r) begin
        if (!rst_r) begin
            st_r <= ST_IDLE;
            role_r <= B_AW;
            ph_r <= 2'd0;
            bit_r <= 5'd0;
            sh_r <= 8'h00;
            ssh_r <= 24'h00_0000;
            left_r <= 8'h00;
            cur_r <= 8'h00;
            rd_r <= 1'b0;
            ptr_r <= 1'b0;
            reg_r <= 8'h00;
            o_wreq <= 1'b0;
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
            o_rsv <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_nack <= 1'b0;
            o_scl_oe <= 1'b0;
            o_sda_oe <= 1'b0;
            o_cs_b <= 1'b1;
            o_sclk <= 1'b0;
            o_mosi <= 1'b0;
        end else begin
            o_wreq <= 1'b0;
            o_rvalid <= 1'b0;
            o_done <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    o_cs_b <= 1'b1;
                    o_sclk <= 1'b0;
                    if (i_start) begin
                        o_busy <= 1'b1;
                        o_nack <= 1'b0;
                        rd_r <= i_rd;
                        ptr_r <= i_use_ptr;
                        reg_r <= i_reg;
                        cur_r <= i_reg;
                        left_r <= i_len;
                        ph_r <= 2'd0;
                        if (i_mode_2w) begin
                            st_r <= ST_START;
                            // plain read skips the pointer write
                            role_r <= (i_rd && !i_use_ptr) ? B_AR : B_AW;
                            cur_r <= (i_rd && !i_use_ptr) ? 8'h00 : i_reg;
                        end else begin
                            st_r <= ST_SBIT;
                            o_cs_b <= 1'b0;
                            o_mosi <= i_reg[7];
                            bit_r <= 5'd0;
                            ssh_r <= {i_reg, i_rd ? `GSP_CMD_READ : `GSP_CMD_WRITE,
                                      i_wdata};
                            o_wreq <= ~i_rd;
                        end
                    end
                end
                ST_START, ST_RSTART: if (tick2) begin
                    // release sda, then scl, then pull sda low with scl high, then scl low
                    ph_r <= ph_r + 2'd1;
                    if (ph_r == 2'd0) begin
                        o_sda_oe <= 1'b0;
                    end else if (ph_r == 2'd1) begin
                        o_scl_oe <= 1'b0;
                    end else if (ph_r == 2'd2) begin
                        if (scl_s) begin
                            o_sda_oe <= 1'b1;
                        end else begin
                            ph_r <= 2'd2;
                        end
                    end else begin
                        o_scl_oe <= 1'b1;
                        st_r <= ST_BIT;
                        bit_r <= 5'd0;
                        sh_r <= (role_r == B_AR) ? taddr(i_strap, 1'b1)
                                                 : taddr(i_strap, 1'b0);
                    end
                end
                ST_BIT, ST_ACK: if (tick2) begin
                    // quarter 0 set sda, 1 release scl, 2 sample, 3 pull scl
                    ph_r <= ph_r + 2'd1;
                    if (ph_r == 2'd0) begin
                        if (st_r == ST_ACK) begin
                            // ack each read byte but the last
                            o_sda_oe <= (role_r == B_RD) && (left_r != 8'h01);
                        end else if (role_r == B_RD) begin
                            o_sda_oe <= 1'b0;
                        end else begin
                            o_sda_oe <= ~sh_r[7];
                        end
                    end else if (ph_r == 2'd1) begin
                        o_scl_oe <= 1'b0;
                    end else if (ph_r == 2'd2) begin
                        if (!scl_s) begin
                            ph_r <= 2'd2;
                        end else if (st_r == ST_BIT) begin
                            sh_r <= {sh_r[6:0], sda_s};
                        end else if (role_r != B_RD && sda_s) begin
                            o_nack <= 1'b1;
                        end
                    end else begin
                        o_scl_oe <= 1'b1;
                        if (st_r == ST_BIT) begin
                            bit_r <= bit_r + 5'd1;
                            if (bit_r == 5'd7) begin
                                st_r <= ST_ACK;
                            end
                        end else begin
                            bit_r <= 5'd0;
                            st_r <= ST_BIT;
                            if (o_nack) begin
                                st_r <= ST_STOP;
                            end else case (role_r)
                                B_AW: begin
                                    role_r <= B_PTR;
                                    sh_r <= reg_r;
                                end
                                B_PTR: begin
                                    if (rd_r) begin
                                        role_r <= B_AR;
                                        st_r <= ST_RSTART;
                                    end else if (left_r == 8'h00) begin
                                        st_r <= ST_STOP;
                                    end else begin
                                        role_r <= B_WD;
                                        sh_r <= i_wdata;
                                        o_wreq <= 1'b1;
                                    end
                                end
                                B_WD: begin
                                    left_r <= left_r - 8'h01;
                                    cur_r <= cur_r + 8'h01;
                                    if (left_r == 8'h01) begin
                                        st_r <= ST_STOP;
                                    end else begin
                                        sh_r <= i_wdata;
                                        o_wreq <= 1'b1;
                                    end
                                end
                                B_AR: begin
                                    role_r <= B_RD;
                                    if (left_r == 8'h00) begin
                                        st_r <= ST_STOP;
                                    end
                                end
                                B_RD: begin
                                    o_rdata <= sh_r;
                                    o_rvalid <= 1'b1;
                                    o_rsv <= rsv_reg(cur_r);
                                    // pointer saturates at the top register
                                    if (cur_r != `GSP_TOP_REG) begin
                                        cur_r <= cur_r + 8'h01;
                                    end
                                    left_r <= left_r - 8'h01;
                                    if (left_r == 8'h01) begin
                                        st_r <= ST_STOP;
                                    end
                                end
                                default: st_r <= ST_STOP;
                            endcase
                        end
                    end
                end
                ST_STOP: if (tick2) begin
                    // sda low, scl high, then sda high
                    ph_r <= ph_r + 2'd1;
                    if (ph_r == 2'd0) begin
                        o_sda_oe <= 1'b1;
                    end else if (ph_r == 2'd1) begin
                        o_scl_oe <= 1'b0;
                    end else if (ph_r == 2'd2) begin
                        if (!scl_s) begin
                            ph_r <= 2'd2;
                        end
                    end else begin
                        o_sda_oe <= 1'b0;
                        st_r <= ST_DONE;
                    end
                end
                ST_SBIT: if (tick4) begin
                    // low half then rising edge; data changes while clock low
                    if (!o_sclk) begin
                        o_sclk <= 1'b1;
                        if (!o_cs_b) begin
                            ssh_r <= {ssh_r[22:0], miso_s};
                        end
                    end else begin
                        o_sclk <= 1'b0;
                        o_mosi <= ssh_r[23];
                        bit_r <= bit_r + 5'd1;
                        if (bit_r == 5'd`GSP_SPI_BITS - 5'd1) begin
                            bit_r <= 5'd0;
                            if (rd_r && left_r != 8'h00) begin
                                st_r <= ST_SEND;
                            end else begin
                                st_r <= ST_DONE;
                            end
                            // the data slot of a read frame carries the first byte
                            if (rd_r) begin
                                o_rdata <= ssh_r[7:0];
                                o_rvalid <= 1'b1;
                            end
                        end
                    end
                end
                ST_SEND: if (tick4) begin
                    // extra read bytes of the burst, eight clocks each
                    o_sclk <= ~o_sclk;
                    if (!o_sclk) begin
                        ssh_r <= {ssh_r[22:0], miso_s};
                    end else if (bit_r == 5'd7) begin
                        bit_r <= 5'd0;
                        left_r <= left_r - 8'h01;
                        o_rdata <= ssh_r[7:0];
                        o_rvalid <= 1'b1;
                        if (left_r == 8'h01) begin
                            st_r <= ST_DONE;
                        end
                    end else begin
                        bit_r <= bit_r + 5'd1;
                    end
                end
                ST_DONE: begin
                    o_cs_b <= 1'b1;
                    o_sclk <= 1'b0;
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    st_r <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
endmodule // gsp_host

/* tb/gsp_host_chk.sv */
// Purpose: port checker for the sensor serial host controller
// Assumes: sees only the ports of gsp_host
// Notes: spi clock edges are counted per frame and judged when select rises
`timescale 1ns/1ps
module gsp_host_chk (
    // clock and reset
    input wire i_clk,
    input wire i_rst_b,
    // command
    input wire i_start,
    input wire i_mode_2w,
    input wire i_rd,
    input wire [7:0] i_len,
    // status and pins
    input wire o_busy,
    input wire o_done,
    input wire o_nack,
    input wire o_scl_oe,
    input wire o_sda_oe,
    input wire o_cs_b,
    input wire o_sclk,
    input wire o_mosi
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    reg sclk_q;
    reg m_q;
    reg rd_q;
    reg [7:0] len_q;
    reg [11:0] edge_r;
    ////////////////////////////////////////////////////////////////////////
    // command capture and rising spi edges inside the current frame
    always @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_q <= 1'b0;
            m_q <= 1'b0;
            rd_q <= 1'b0;
            len_q <= 8'h00;
            edge_r <= 12'h000;
        end else begin
            sclk_q <= o_sclk;
            if (i_start && !o_busy) begin
                m_q <= i_mode_2w;
                rd_q <= i_rd;
                len_q <= i_len;
            end
            if (o_cs_b)
                edge_r <= 12'h000;
            else if (o_sclk && !sclk_q)
                edge_r <= edge_r + 12'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sel_idle_a: assert property (o_cs_b |-> !o_sclk)
        else $error("spi clock high while deselected");
    sel_mode_a: assert property (!o_cs_b |-> !m_q)
        else $error("select low in two-wire mode");
    pin_mode_a: assert property ((o_scl_oe || o_sda_oe) |-> m_q)
        else $error("two-wire pins pulled in four-wire mode");
    mosi_hold_a: assert property ($rose(o_sclk) |-> $stable(o_mosi))
        else $error("mosi moved at rising spi clock");
    sclk_pulse_a: assert property ($rose(o_sclk) |=> o_sclk ##1 o_sclk ##1 !o_sclk)
        else $error("spi clock high time wrong");
    wr_bits_a: assert property ($rose(o_cs_b) && !rd_q |-> edge_r == 12'd24)
        else $error("write frame not 24 clocks");
    rd_bits_a: assert property ($rose(o_cs_b) && rd_q |->
        edge_r == 12'd24 + {1'b0, len_q, 3'b000})
        else $error("read burst clock count wrong");
    done_free_a: assert property (o_done |-> o_cs_b && !o_scl_oe && !o_sda_oe)
        else $error("bus not released at done");
    nack_stop_a: assert property ($rose(o_nack) |-> ##[1:120] o_done)
        else $error("nack not followed by end of frame");
endmodule // gsp_host_chk

bind gsp_host gsp_host_chk gsp_host_chk_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start), .i_mode_2w(i_mode_2w),
    .i_rd(i_rd), .i_len(i_len), .o_busy(o_busy), .o_done(o_done), .o_nack(o_nack),
    .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_cs_b(o_cs_b), .o_sclk(o_sclk),
    .o_mosi(o_mosi)
);

/* tb/gsp_dev_model.sv */
// Purpose: behavioural sensor register port on both serial buses
// Assumes: host makes both clocks; 256 byte register space
// Notes: no clock stretching; released lines are pulled up by the bench
`timescale 1ns/1ps
module gsp_dev_model (
    // two-wire side
    input wire i_scl,
    input wire i_sda,
    output reg o_sda_oe,
    // four-wire side
    input wire i_cs_b,
    input wire i_sclk,
    input wire i_mosi,
    output reg o_miso,
    // straps
    input wire i_sel_2w,
    input wire i_strap
);
    reg [7:0] mem [0:255];
    reg [7:0] sh = 0;
    reg [7:0] ptr = 0;
    reg [7:0] sp = 0;
    reg [23:0] sw = 0;
    reg act = 0;
    reg rep = 0;
    reg srd = 0;
    integer bn = 0, st = 4, sc = 0, i;
    wire [7:0] adr = i_strap ? 8'hA0 : 8'h9E;
    ////////////////////////////////////////////////////////////////////////
    // known pattern so the bench can predict every byte
    initial begin
        for (i = 0; i < 256; i = i + 1) mem[i] = 8'(i ^ 90);
        o_sda_oe = 0;
        o_miso = 0;
    end
    // start and stop are data edges while the clock is high
    always @(negedge i_sda) if (i_scl === 1'b1 && i_sel_2w) begin
        rep = act;
        act = 1;
        bn = -1;
        st = 0;
    end
    always @(posedge i_sda) if (i_scl === 1'b1 && act) begin
        act = 0;
        o_sda_oe = 0;
    end
    // bits are taken on the rising clock, host ack in the ninth
    always @(posedge i_scl) if (act) begin
        if (bn >= 0 && bn < 8) sh = {sh[6:0], i_sda};
        if (bn == 8 && st == 3 && i_sda) st = 4;
    end
    // the line changes only while the clock is low
    always @(negedge i_scl) if (act) begin
        bn = bn + 1;
        if (bn == 9) bn = 0;
        o_sda_oe = 0;
        if (bn == 8 && st == 0 && sh[7:1] == adr[7:1]) begin
            st = sh[0] ? 3 : 1;
            if (sh[0] && !rep) ptr = 0;
            o_sda_oe = 1;
        end else if (bn == 8 && st == 0) st = 4;
        else if (bn == 8 && st == 1) begin
            ptr = sh;
            st = 2;
            o_sda_oe = 1;
        end else if (bn == 8 && st == 2) begin
            mem[ptr] = sh;
            if (ptr != 8'hFF) ptr = ptr + 1;
            o_sda_oe = 1;
        end else if (bn == 8 && st == 3 && ptr != 8'hFF) ptr = ptr + 1;
        if (st == 3 && bn < 8) o_sda_oe = !mem[ptr][7 - bn];
    end
    // four-wire frame; clock ignored while deselected
    always @(negedge i_cs_b) begin
        sc = 0;
        srd = 0;
    end
    always @(posedge i_cs_b) o_miso = !o_miso;
    always @(posedge i_sclk) if (!i_cs_b && !i_sel_2w) begin
        sw = {sw[22:0], i_mosi};
        sc = sc + 1;
        if (sc == 16) srd = sw[7];
        if (sc == 16) sp = sw[15:8];
        if (sc == 24 && !srd) mem[sw[23:16]] = sw[7:0];
    end
    always @(negedge i_sclk) if (!i_cs_b && srd && sc >= 16) begin
        if (sc > 16 && sc % 8 == 0 && sp != 8'hFF) sp = sp + 1;
        o_miso = mem[sp][7 - sc % 8];
    end
endmodule // gsp_dev_model

/* tb/testbench.sv */
// Purpose: self-checking bench for the sensor serial host controller
// Assumes: sensor model on both buses, pull-ups on the two-wire lines
// Notes: expected bytes come from a local copy of the register space
`timescale 1ns/1ps
module testbench;
    reg i_clk = 0, i_rst_b = 0, i_start = 0, i_mode_2w = 1, i_strap = 0;
    reg i_rd = 0, i_use_ptr = 0, dev_strap = 0;
    reg [7:0] i_reg = 0, i_len = 0, i_wdata = 0;
    wire o_wreq, o_rvalid, o_rsv, o_busy, o_done, o_nack, o_scl_oe, o_sda_oe;
    wire o_cs_b, o_sclk, o_mosi, miso, dev_oe;
    wire [7:0] o_rdata;
    wire scl = !o_scl_oe;
    wire sda = !(o_sda_oe | dev_oe);
    reg [7:0] rm [0:255];
    reg [7:0] eq [$];
    reg [7:0] wq [$];
    integer bad_count = 0, cmp_count = 0, cyc = 0, i, last;
    always #50 i_clk = !i_clk;
    gsp_host gsp_host_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(i_start),
        .i_mode_2w(i_mode_2w), .i_strap(i_strap), .i_rd(i_rd), .i_use_ptr(i_use_ptr),
        .i_reg(i_reg), .i_len(i_len), .i_wdata(i_wdata), .o_wreq(o_wreq),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_rsv(o_rsv), .o_busy(o_busy),
        .o_done(o_done), .o_nack(o_nack), .i_scl(scl), .o_scl_oe(o_scl_oe), .i_sda(sda),
        .o_sda_oe(o_sda_oe), .o_cs_b(o_cs_b), .o_sclk(o_sclk), .o_mosi(o_mosi),
        .i_miso(miso));
    gsp_dev_model gsp_dev_model_inst (.i_scl(scl), .i_sda(sda), .o_sda_oe(dev_oe),
        .i_cs_b(o_cs_b), .i_sclk(o_sclk), .i_mosi(o_mosi), .o_miso(miso),
        .i_sel_2w(i_mode_2w), .i_strap(dev_strap));
    ////////////////////////////////////////////////////////////////////////
    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
            if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task chk(input string nm, input [7:0] e, input [7:0] s);
        begin
            cmp_count = cmp_count + 1;
            if (s !== e) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    // one command: predict bytes and side effects, then follow it to done
    task cmd(input m, input rd, input up, input [7:0] r, input [7:0] n, input nk);
        integer k, p, t, nb, adv;
        reg [7:0] d;
        begin
            p = (m && rd && !up) ? 0 : r;
            t = nk ? 0 : (m ? n : (rd ? n + 1 : 1));
            nb = 0;
            adv = 0;
            for (k = 0; k < t; k = k + 1) begin
                d = $urandom;
                if (rd) eq.push_back(rm[p]);
                else wq.push_back(d);
                if (!rd) rm[p] = d;
                last = p;
                if (p < 255) p = p + 1;
            end
            // a fresh edge, so i_start is never driven twice in one step
            @(negedge i_clk);
            {i_mode_2w, i_rd, i_use_ptr, i_reg, i_len} = {m, rd, up, r, n};
            if (wq.size() > 0) i_wdata = wq[0];
            i_start = 1;
            for (k = 0; k < 20000; k = k + 1) begin
                @(negedge i_clk);
                i_start = 0;
                if (adv && wq.size() > 0) i_wdata = wq[0];
                adv = 0;
                if (o_wreq === 1'b1 && wq.size() > 0) begin
                    d = wq.pop_front();
                    adv = 1;
                end
                if (o_wreq === 1'b1 || o_rvalid === 1'b1) nb = nb + 1;
                if (o_rvalid === 1'b1 && eq.size() > 0)
                    chk("rdata", eq.pop_front(), o_rdata);
                if (o_done === 1'b1) k = 30000;
            end
            if (k == 20000) chk("done", 8'h01, 8'h00);
            chk("busy", 8'h00, {7'h00, o_busy});
            chk("nack", {7'h00, nk}, {7'h00, o_nack});
            if (m || rd) chk("bytes", t, nb);
            if (m && rd && !nk) chk("rsv", {7'h00, last >= 176 && last <= 192}, {7'h00, o_rsv});
            eq.delete();
            wq.delete();
        end
    endtask
    task tend(input string nm);
        $display("test %s finished", nm);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // ceiling well above the expected run of about 11500 cycles
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            bad_count = bad_count + 1;
            summarize;
        end
    end
    initial begin
        i = $urandom(38897);
        for (i = 0; i < 256; i = i + 1) rm[i] = 8'(i ^ 90);
        repeat (8) @(negedge i_clk);
        i_rst_b = 1;
        repeat (3) @(negedge i_clk);
        cmd(1, 0, 0, 8'h10, 3, 0);
        cmd(1, 1, 1, 8'h10, 4, 0);
        tend("two-wire write and pointed read");
        for (i = 1; i < 3; i = i + 1) cmd(1, 1, 0, 8'h00, i, 0);
        cmd(1, 1, 1, 8'hFE, 3, 0);
        cmd(1, 1, 1, 8'hAF, 2, 0);
        tend("two-wire plain, top and reserved reads");
        {i_strap, dev_strap} = 2'b11;
        cmd(1, 0, 0, 8'h20, 1, 0);
        dev_strap = 0;
        cmd(1, 0, 0, 8'h21, 1, 1);
        i_strap = 0;
        cmd(1, 1, 1, 8'h20, 2, 0);
        tend("address strap and nack");
        for (i = 0; i < 4; i = i + 1) cmd(0, 0, 0, 8'h30 + 8'($urandom % 16), 0, 0);
        cmd(0, 1, 0, 8'h30, 15, 0);
        tend("four-wire write and burst read");
        summarize;
    end
endmodule // testbench
